// [verilog/cqw_wait_unit.sv]
/*
 * Command queue wait unit: executes the head command of the buffered queue,
 * holding it while wait conditions are pending and issuing moves.
 * Assumes the sequencer holds head_cmd stable while head_valid is high and
 * advances on head_taken; drive inputs are asynchronous pins.
 */
`timescale 1ns/1ps
module cqw_wait_unit
    import cqw_pkg::*;
#(
    parameter int NUM_IN   = 8,
    parameter int TICK_CYC = CQW_TICK_CYC,
    parameter int MS_CYC   = CQW_MS_CYC
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire cqw_cmd_t             head_cmd,
    input  wire logic                 head_valid,
    output logic                      head_taken,
    input  wire logic [CQW_ARG_W-1:0] reg_value,
    input  wire logic                 multitask_mode,
    input  wire logic [NUM_IN-1:0]    drive_in,
    input  wire logic                 jog_fwd_in,
    input  wire logic                 jog_rev_in,
    output logic                      jog_fwd,
    output logic                      jog_rev,
    output logic                      jog_enabled,
    output logic                      move_start,
    output cqw_move_t                 move_req,
    input  wire logic                 move_busy,
    input  wire logic                 position_reached,
    output logic                      waiting
);
    typedef enum logic [3:0] {
        CQW_IDLE = 4'b0001,
        CQW_WIN  = 4'b0010,
        CQW_WMV  = 4'b0100,
        CQW_WTM  = 4'b1000
    } cqw_state_t;

    cqw_state_t state;
    cqw_state_t next_state;

    // Input synchronisers; stage one is read only by stage two
    logic [NUM_IN-1:0] in_s1;
    logic [NUM_IN-1:0] in_s2;
    logic [NUM_IN-1:0] in_prev;
    logic [1:0]        jog_s1;
    logic [1:0]        jog_s2;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            in_s1   <= '0;
            in_s2   <= '0;
            in_prev <= '0;
            jog_s1  <= '0;
            jog_s2  <= '0;
        end else begin
            in_s1   <= drive_in;
            in_s2   <= in_s1;
            in_prev <= in_s2;
            jog_s1  <= {jog_rev_in, jog_fwd_in};
            jog_s2  <= jog_s1;
        end
    end

    // Latched wait parameters
    logic [CQW_INSEL_W-1:0] in_sel;
    logic [1:0]             in_cond;
    logic [15:0]            wait_cnt;
    logic                   time_ms;
    logic [CQW_ARG_W-1:0]   chg_dist;
    logic [CQW_ARG_W-1:0]   chg_vel;
    logic                   move_pos;   // wait for position rather than move end

    // Head decode
    wire       is_op    = head_valid && state == CQW_IDLE;
    wire [3:0] op       = head_cmd.op;
    wire [1:0] arg_cond = head_cmd.arg[CQW_COND_LSB +: 2];
    wire [CQW_INSEL_W-1:0] arg_sel = head_cmd.arg[CQW_INSEL_LSB +: CQW_INSEL_W];
    // Durations beyond 320.00 s are clamped to the largest accepted value
    wire [15:0] arg_wt  = (head_cmd.arg > CQW_ARG_W'(CQW_WT_MAX)) ?
                          16'(CQW_WT_MAX) : head_cmd.arg[15:0];
    wire [15:0] arg_ms  = {1'b0, reg_value[CQW_DELAY_BITS-1:0]};            // [R9]
    wire        mt_wait = multitask_mode && (op == CQW_OP_WAIT_MOVE ||
                          op == CQW_OP_WAIT_POS);

    // Edges count only once the chain holds real pin samples; a pin that idles
    // high would otherwise show a false rise just after reset
    logic [1:0] fill;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fill <= 2'h0;
        end else if (fill != 2'h3) begin
            fill <= fill + 2'h1;
        end
    end
    wire edge_ok = fill == 2'h3;

    // Input condition evaluation on synchronised samples
    wire in_now  = in_s2[in_sel];
    wire in_was  = in_prev[in_sel];
    wire in_hit  = (in_cond == CQW_COND_HIGH && in_now) ||
                   (in_cond == CQW_COND_LOW  && !in_now) ||
                   (in_cond == CQW_COND_RISE && edge_ok && in_now && !in_was) ||
                   (in_cond == CQW_COND_FALL && edge_ok && !in_now && in_was); // [R1]

    // Timer ticks: 10 ms for wait_time, 1 ms for the register delay
    logic tick10;
    logic tick1;
    wire  tm_run  = state == CQW_WTM;
    cqw_tick_div #(.DIV(TICK_CYC)) u_tick10 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .run     (tm_run && !time_ms),
        .tick    (tick10)
    );
    cqw_tick_div #(.DIV(MS_CYC)) u_tick1 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .run     (tm_run && time_ms),
        .tick    (tick1)
    );
    wire tm_tick = time_ms ? tick1 : tick10;                                 // [R10]
    wire tm_done = tm_tick && wait_cnt == 16'h0001;

    // Wait on move or position; the present move_busy level covers feeds,
    // jogs and following alike
    wire mv_done = move_pos ? position_reached : !move_busy;                 // [R4] [R5]

    // Next state and queue release
    always_comb begin
        next_state = state;
        head_taken = 1'b0;
        unique case (state)
            CQW_IDLE: begin
                if (is_op) begin
                    if (op == CQW_OP_WAIT_IN) begin
                        next_state = CQW_WIN;                                // [R1]
                    end else if (mt_wait) begin
                        next_state = CQW_WMV;                                // [R4] [R5]
                    end else if (op == CQW_OP_WAIT_TIME && arg_wt != 16'h0000) begin
                        next_state = CQW_WTM;                                // [R8]
                    end else if (op == CQW_OP_WAIT_REG && arg_ms != 16'h0000) begin
                        next_state = CQW_WTM;                                // [R9]
                    end else begin
                        head_taken = 1'b1;                                   // [R10]
                    end
                end
            end
            CQW_WIN: begin
                if (in_hit) begin
                    next_state = CQW_IDLE;
                    head_taken = 1'b1;
                end
            end
            CQW_WMV: begin
                if (mv_done) begin
                    next_state = CQW_IDLE;
                    head_taken = 1'b1;
                end
            end
            CQW_WTM: begin
                if (tm_done) begin
                    next_state = CQW_IDLE;
                    head_taken = 1'b1;
                end
            end
        endcase
    end

    // State and wait parameters
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state    <= CQW_IDLE;
            in_sel   <= '0;
            in_cond  <= CQW_COND_LOW;
            wait_cnt <= 16'h0000;
            time_ms  <= 1'b0;
            move_pos <= 1'b0;
        end else begin
            state <= next_state;
            if (is_op) begin
                in_sel   <= arg_sel;
                in_cond  <= arg_cond;
                time_ms  <= op == CQW_OP_WAIT_REG;
                move_pos <= op == CQW_OP_WAIT_POS;
                wait_cnt <= (op == CQW_OP_WAIT_REG) ? arg_ms : arg_wt;
            end else if (tm_tick) begin
                wait_cnt <= wait_cnt - 16'h0001;                             // [R8]
            end
        end
    end

    // Speed-change values and jog permission, updated as commands retire
    wire exec = is_op && head_taken;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            chg_dist    <= '0;
            chg_vel     <= '0;
            jog_enabled <= 1'b0;
        end else if (exec) begin
            if (op == CQW_OP_CHG_DIST) chg_dist <= head_cmd.arg;             // [R6]
            if (op == CQW_OP_CHG_VEL)  chg_vel  <= head_cmd.arg;             // [R6]
            if (op == CQW_OP_JOG_EN)   jog_enabled <= 1'b1;                  // [R3]
            if (op == CQW_OP_JOG_DIS)  jog_enabled <= 1'b0;                  // [R3]
        end
    end

    // Move launch; a move waiting behind an input wait goes out two cycles
    // after the wait releases: the head retires at once, then move_start is registered
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            move_start <= 1'b0;
            move_req   <= '0;
        end else begin
            move_start <= exec && (op == CQW_OP_MOVE || op == CQW_OP_FEED_CHG); // [R2]
            if (exec && (op == CQW_OP_MOVE || op == CQW_OP_FEED_CHG)) begin
                move_req.speed_change <= op == CQW_OP_FEED_CHG;               // [R6]
                move_req.chg_dist     <= chg_dist;
                move_req.chg_vel      <= chg_vel;
            end
        end
    end

    // Jog outputs gated by the enable; registered to keep them glitch free
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            jog_fwd <= 1'b0;
            jog_rev <= 1'b0;
        end else begin
            jog_fwd <= jog_enabled && jog_s2[0];                             // [R3]
            jog_rev <= jog_enabled && jog_s2[1];                             // [R3]
        end
    end

    assign waiting = state != CQW_IDLE;
endmodule

// [verilog/cqw_pkg.sv]
/*
 * Package for the command queue wait unit: command codes, field layouts,
 * timing constants and the packed carriers shared by the design files.
 * Assumes a single 25 MHz system clock and a synchronous active-low reset.
 */
// What this block does
// R1: wait_for_input holds the queue until the named input meets its condition.
// R2: A move after a satisfied input wait launches two cycles after detection.
// R3: Jog inputs move the motor only between jog_enable_cmd and jog_disable_cmd.
// R4: With multitask_mode, wait_on_move holds the queue until the last move finishes.
// R5: With multitask_mode, wait_position holds until the change_distance position is reached.
// R6: feed_speed_change_move applies one speed change from preset distance and velocity.
// R7: The host places wait_position before each further distance and velocity pair.
// R8: wait_time holds for hundredths of a second, accepting up to 320.00 seconds.
// R9: wait_delay_register waits milliseconds from the low 15 bits of a register.
// R10: wait_time counts 10 ms ticks; zero duration releases in the same cycle it reaches the head.
package cqw_pkg;

    // Command opcodes presented at the queue head
    localparam logic [3:0] CQW_OP_NOP       = 4'h0;
    localparam logic [3:0] CQW_OP_WAIT_IN   = 4'h1;
    localparam logic [3:0] CQW_OP_WAIT_MOVE = 4'h2;
    localparam logic [3:0] CQW_OP_WAIT_POS  = 4'h3;
    localparam logic [3:0] CQW_OP_WAIT_TIME = 4'h4;
    localparam logic [3:0] CQW_OP_WAIT_REG  = 4'h5;
    localparam logic [3:0] CQW_OP_JOG_EN    = 4'h6;
    localparam logic [3:0] CQW_OP_JOG_DIS   = 4'h7;
    localparam logic [3:0] CQW_OP_CHG_DIST  = 4'h8;
    localparam logic [3:0] CQW_OP_CHG_VEL   = 4'h9;
    localparam logic [3:0] CQW_OP_FEED_CHG  = 4'hA;
    localparam logic [3:0] CQW_OP_MOVE      = 4'hB;

    // Input wait conditions
    localparam logic [1:0] CQW_COND_LOW     = 2'h0;
    localparam logic [1:0] CQW_COND_HIGH    = 2'h1;
    localparam logic [1:0] CQW_COND_RISE    = 2'h2;
    localparam logic [1:0] CQW_COND_FALL    = 2'h3;

    // Argument field layout
    localparam int CQW_ARG_W      = 32;
    localparam int CQW_INSEL_W    = 3;
    localparam int CQW_INSEL_LSB  = 0;
    localparam int CQW_COND_LSB   = 4;
    localparam int CQW_DELAY_BITS = 15;
    localparam int CQW_WT_MAX     = 32000;   // 320.00 s in hundredths

    // Timing
    localparam int CQW_CLK_HZ     = 25_000_000;
    localparam int CQW_MS_US      = 1000;
    localparam int CQW_TICK_MS    = 10;
    localparam int CQW_MS_CYC     = CQW_CLK_HZ / 1000 * CQW_MS_US / 1000;
    localparam int CQW_TICK_CYC   = CQW_MS_CYC * CQW_TICK_MS;

    // Queue head command
    typedef struct packed {
        logic [3:0]           op;
        logic [CQW_ARG_W-1:0] arg;
    } cqw_cmd_t;

    // Move request toward the move generator
    typedef struct packed {
        logic                 speed_change;
        logic [CQW_ARG_W-1:0] chg_dist;
        logic [CQW_ARG_W-1:0] chg_vel;
    } cqw_move_t;

endpackage

// [verilog/cqw_tick_div.sv]
/*
 * Tick divider: one-cycle enable pulse every DIV cycles while run is high.
 * Assumes the same clock and reset as the wait unit.
 */
`timescale 1ns/1ps
module cqw_tick_div
    import cqw_pkg::*;
#(
    parameter int DIV = 1000
) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic run,
    output logic      tick
);
    logic [$clog2(DIV+1)-1:0] cnt;
    wire  last = (cnt == ($clog2(DIV+1))'(DIV - 1));

    // Restarts from zero whenever run drops so each wait gets whole periods
    always_ff @(posedge ref_clk) begin
        if (!rstn || !run) begin
            cnt <= '0;
        end else if (last) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    assign tick = run && last;
endmodule

// [sim/cqw_move_model.sv]
/* Move generator stand-in: busy for BUSY cycles per launch.
   Assumes the wait unit's clock and reset. */
`timescale 1ns/1ps
module cqw_move_model
    import cqw_pkg::*;
#(
    parameter int BUSY = 12
) (
    input  wire logic      ref_clk,
    input  wire logic      rstn,
    input  wire logic      move_start,
    input  wire cqw_move_t move_req,
    output logic           move_busy,
    output logic           position_reached
);
    logic [7:0] pos;
    // Travel count restarts per launch, so only the latest move counts
    always_ff @(posedge ref_clk) begin
        if (!rstn) pos <= 8'h00;
        else if (move_start) pos <= 8'h01;
        else if (move_busy) pos <= pos + 8'h01;
    end
    // Flag only while moving; a stale one would free a wait early
    assign move_busy        = pos != 8'h00 && pos <= 8'(BUSY);
    assign position_reached = move_busy && pos >= move_req.chg_dist[7:0];
endmodule

// [sim/cqw_wait_unit_chk.sv]
/* Checker for the wait unit: hold spans, launches, jog gating.
   Assumes it sees top ports only; bound below. */
`timescale 1ns/1ps
module cqw_wait_unit_chk
    import cqw_pkg::*;
#(
    parameter int TICK_CYC = CQW_TICK_CYC,
    parameter int MS_CYC   = CQW_MS_CYC
) (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire cqw_cmd_t    head_cmd,
    input wire logic        head_valid,
    input wire logic        head_taken,
    input wire logic [31:0] reg_value,
    input wire logic        multitask_mode,
    input wire logic        jog_fwd,
    input wire logic        jog_enabled,
    input wire logic        move_start,
    input wire cqw_move_t   move_req,
    input wire logic        move_busy,
    input wire logic        position_reached,
    input wire logic        waiting
);
    wire [3:0] op   = head_cmd.op;
    wire       took = head_valid && head_taken;
    longint    held;
    longint    tw;
    longint    dw;
    // Expected holds; time clamps at its top, delay keeps low bits only
    assign tw = longint'(head_cmd.arg > CQW_WT_MAX ? CQW_WT_MAX : head_cmd.arg) * TICK_CYC;
    assign dw = longint'(reg_value[CQW_DELAY_BITS-1:0]) * MS_CYC;
    // Cycles spent holding the present head
    always_ff @(posedge ref_clk) begin
        if (!rstn || !waiting || took) held <= 0;
        else held <= held + 1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_move_launch: assert property (
        took && op == CQW_OP_MOVE |=> move_start) else $error("move not launched");
    a_feed_change: assert property (
        took && op == CQW_OP_FEED_CHG |=> move_start && move_req.speed_change)
        else $error("speed change move missing");
    a_jog_off: assert property (
        took && op == CQW_OP_JOG_DIS |=> !jog_enabled) else $error("jog still enabled");
    a_jog_gate: assert property (
        jog_fwd |-> jog_enabled || $past(jog_enabled)) else $error("jog while disabled");
    a_move_wait: assert property (
        took && multitask_mode && op == CQW_OP_WAIT_MOVE |-> !move_busy)
        else $error("move wait freed while busy");
    a_pos_wait: assert property (
        took && multitask_mode && op == CQW_OP_WAIT_POS |-> position_reached)
        else $error("position wait freed early");
    a_time_span: assert property (
        took && op == CQW_OP_WAIT_TIME |-> held + 2 >= tw && held <= tw + 1)
        else $error("time wait span wrong");
    a_delay_span: assert property (
        took && op == CQW_OP_WAIT_REG |-> held + 2 >= dw && held <= dw + 1)
        else $error("register wait span wrong");
endmodule
bind cqw_wait_unit cqw_wait_unit_chk #(.TICK_CYC(TICK_CYC), .MS_CYC(MS_CYC)) u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .head_cmd(head_cmd), .head_valid(head_valid),
    .head_taken(head_taken), .reg_value(reg_value), .multitask_mode(multitask_mode),
    .jog_fwd(jog_fwd), .jog_enabled(jog_enabled), .move_start(move_start),
    .move_req(move_req), .move_busy(move_busy), .position_reached(position_reached),
    .waiting(waiting)
);

// [sim/command_queue_wait_unit_tb.sv]
/* Bench for the wait unit: table of quick commands, then held waits.
   Assumes the move stand-in and the bound checker are compiled too. */
`timescale 1ns/1ps
module command_queue_wait_unit_tb;
    import cqw_pkg::*;
    typedef struct packed {logic [3:0] op; logic [31:0] arg; logic mv;} cqw_row_t;
    logic        ref_clk = 0;
    logic        rstn = 0;
    cqw_cmd_t    head_cmd = '0;
    logic        head_valid = 0;
    logic [31:0] reg_value = 32'h0000_8000;
    logic        multitask_mode = 0;
    logic [7:0]  drive_in = 8'h09;
    logic        jog_fwd_in = 0;
    logic        jog_rev_in = 0;
    logic        head_taken, jog_fwd, jog_rev, jog_enabled, move_start;
    logic        move_busy, position_reached, waiting;
    cqw_move_t   move_req;
    int          miscompares = 0;
    int          tests_run = 0;
    int          n;
    // Quick retirements: pin 0 high, pin 1 low, register low bits zero
    cqw_row_t    rows [7] = '{'{CQW_OP_NOP, '0, 0}, '{CQW_OP_WAIT_IN, 32'h0000_0010, 0},
        '{CQW_OP_WAIT_IN, 32'h0000_0001, 0}, '{CQW_OP_MOVE, '0, 1},
        '{CQW_OP_WAIT_MOVE, '0, 0}, '{CQW_OP_WAIT_TIME, '0, 0}, '{CQW_OP_WAIT_REG, '0, 0}};
    always #20 ref_clk = ~ref_clk;
    cqw_wait_unit #(.TICK_CYC(10), .MS_CYC(2)) u_dut (.ref_clk, .rstn, .head_cmd,
        .head_valid, .head_taken, .reg_value, .multitask_mode, .drive_in, .jog_fwd_in,
        .jog_rev_in, .jog_fwd, .jog_rev, .jog_enabled, .move_start, .move_req,
        .move_busy, .position_reached, .waiting);
    cqw_move_model u_mov (.ref_clk, .rstn, .move_start, .move_req, .move_busy,
        .position_reached);
    // Every check counts; a mismatch reports at once
    task automatic chk(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("Error at %0t ns: %s", $time, what);
        end
    endtask
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait for retirement; returns on the retiring edge
    task automatic take(input int lim);
        n = 0;
        @(negedge ref_clk);
        while (head_taken !== 1'b1) begin
            if (n++ == lim) begin
                chk(1'b0, "head never retired");
                final_report;
            end
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
    endtask
    task automatic put(input logic [3:0] op, input logic [31:0] arg);
        @(posedge ref_clk);
        head_cmd <= '{op, arg};
        head_valid <= 1'b1;
    endtask
    task automatic issue(input logic [3:0] op, input logic [31:0] arg, input logic mv,
                         input int lim);
        put(op, arg);
        take(lim);
        head_valid <= 1'b0;
        @(negedge ref_clk);
        chk(move_start === mv, "launch pulse wrong");
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({head_taken, waiting, move_start, jog_enabled, jog_fwd, jog_rev} === 6'h00
            && move_req === '0, "busy in reset");
        @(posedge ref_clk) rstn <= 1'b1;
        foreach (rows[i]) issue(rows[i].op, rows[i].arg, rows[i].mv, 4);
        $display("table done");
        issue(CQW_OP_WAIT_TIME, 32'h0000_0002, 0, 40);
        chk(n >= 18 && n <= 22, "time span");
        @(posedge ref_clk) reg_value <= 32'h0001_8003;
        issue(CQW_OP_WAIT_REG, '0, 0, 40);
        chk(n >= 4 && n <= 8, "delay span");
        @(posedge ref_clk) jog_fwd_in <= 1'b1;
        issue(CQW_OP_JOG_EN, '0, 0, 2);
        repeat (5) @(negedge ref_clk);
        chk({jog_fwd, jog_rev, jog_enabled} === 3'h5, "jog not passed");
        @(posedge ref_clk) jog_rev_in <= 1'b1;
        repeat (5) @(negedge ref_clk);
        chk({jog_fwd, jog_rev, jog_enabled} === 3'h7, "reverse jog not passed");
        issue(CQW_OP_JOG_DIS, '0, 0, 2);
        repeat (5) @(negedge ref_clk);
        chk({jog_fwd, jog_rev, jog_enabled} === 3'h0, "jog after disable");
        $display("jog done");
        @(posedge ref_clk) multitask_mode <= 1'b1;
        issue(CQW_OP_MOVE, '0, 1, 2);
        issue(CQW_OP_WAIT_MOVE, '0, 0, 30);
        chk(n >= 6 && move_busy === 1'b0, "move wait early");
        issue(CQW_OP_CHG_DIST, 32'h0000_0008, 0, 2);
        issue(CQW_OP_CHG_VEL, 32'h0000_0007, 0, 2);
        issue(CQW_OP_FEED_CHG, '0, 1, 2);
        chk(move_req === {1'h1, 32'h0000_0008, 32'h0000_0007}, "feed request");
        issue(CQW_OP_WAIT_POS, '0, 0, 30);
        chk(n >= 3 && position_reached === 1'b1, "position wait early");
        $display("multitask done");
        // Pin 3 already high: only a fresh rise frees the wait
        put(CQW_OP_WAIT_IN, 32'h0000_0023);
        repeat (3) @(posedge ref_clk) drive_in[3] <= 1'b0;
        @(negedge ref_clk);
        chk(waiting === 1'b1, "input wait not holding");
        repeat (3) @(posedge ref_clk);
        drive_in[3] <= 1'b1;
        take(8);
        chk(n >= 1, "rise wait early");
        head_cmd <= '{CQW_OP_MOVE, '0};
        @(negedge ref_clk);
        chk(head_taken === 1'b1, "move after input held");
        @(posedge ref_clk) head_valid <= 1'b0;
        @(negedge ref_clk);
        chk(move_start === 1'b1, "move not launched");
        put(CQW_OP_WAIT_IN, 32'h0000_0033);
        repeat (3) @(posedge ref_clk);
        drive_in[3] <= 1'b0;
        take(8);
        chk(n >= 1, "fall wait early");
        head_valid <= 1'b0;
        $display("input waits done");
        final_report;
    end
endmodule
